// [pbc_pkg.sv]
/*
 * Constants for the basic control register block of a 10/100 PHY:
 * management addresses, bit positions, defaults, frame lengths, timing.
 * Assumes a single 20 MHz system clock.
 */
`default_nettype none

package pbc_pkg;

    // ****************************************
    // Management addresses
    // ****************************************
    localparam logic [4:0] CTRL_ADDR  = 5'h00;
    localparam logic [4:0] DSTAT_ADDR = 5'h11;

    // ****************************************
    // Control register bit positions
    // ****************************************
    localparam int CB_RESET  = 15;
    localparam int CB_LOOP   = 14;
    localparam int CB_RATE   = 13;
    localparam int CB_ANEN   = 12;
    localparam int CB_LPWR   = 11;
    localparam int CB_ISO    = 10;
    localparam int CB_ANRST  = 9;
    localparam int CB_DUPLEX = 8;
    localparam int CB_CTEST  = 7;

    // ****************************************
    // Detailed status register bit positions
    // ****************************************
    localparam int DB_RATE   = 15;
    localparam int DB_DUPLEX = 14;
    localparam int DB_LMX_LO = 11;
    localparam int LMX_MAX_W = 3;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic RATE_RST  = 1'b1;
    localparam logic ANEN_RST  = 1'b1;
    localparam logic [4:0] ISO_ADDR = 5'h00;

    // ****************************************
    // Management frame fields
    // ****************************************
    localparam int         PRE_BITS_DEF = 32;
    localparam logic [5:0] HDR_LAST     = 6'h0D;
    localparam logic [5:0] TA_LAST      = 6'h01;
    localparam logic [5:0] DATA_LAST    = 6'h0F;
    localparam logic [1:0] FR_START     = 2'h1;
    localparam logic [1:0] OP_READ      = 2'h2;
    localparam logic [1:0] OP_WRITE     = 2'h1;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS   = 50;
    localparam int SW_RESET_NS     = 2000;
    localparam int SW_RESET_CYCLES = (SW_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [4:0] {
        MD_PRE  = 5'h01,
        MD_HDR  = 5'h02,
        MD_TA   = 5'h04,
        MD_RDAT = 5'h08,
        MD_WDAT = 5'h10
    } pbc_mdio_e;

endpackage

`default_nettype wire

// [pbc_control.sv]
/*
 * Basic control register of a 10/100 PHY behind a serial management port,
 * with the detailed status register holding a maximum-tracking group.
 * Assumes mdc and mdio_in are synchronous to sys_clk and far slower.
 */
// Function
// [RULE1] Tracking group holds the largest monitored state; smaller states never replace it.
// [RULE2] Group holds until reset or read; a read reloads the present state.
// [RULE3] Self-clearing bits reset to zero and clear on their own after acting.
// [RULE4] 16-bit control register sits at management address zero.
// [RULE5] Writing one to bit 15 restores all defaults and idles state machines.
// [RULE6] During soft reset bit 15 reads one and accesses are ignored.
// [RULE7] Loopback disables line transmitter, receiver, collision detect; loops MAC data back.
// [RULE8] Collision test bit keeps collision detect on during loopback.
// [RULE9] In loopback receive valid follows transmit enable within 512 bit times.
// [RULE10] In hardware strap mode rate comes from the speed select pin.
// [RULE11] In hardware strap mode status bit 17.15 shows active link speed.
// [RULE12] Software mode with autoneg on takes speed from the autoneg result.
// [RULE13] Software mode with autoneg off: bit 13 picks 10 or 100 Mbps.
// [RULE14] In hardware strap mode autoneg enable comes from the select pin.
// [RULE15] Software mode: bit 12 enables autoneg, else bits 13 and 8 rule.
// [RULE16] Isolate defaults to one only when the strapped address is zero.
// [RULE17] Bits 6 to 0 read zero; the manager writes defaults there.
// [RULE18] Defaults: bits 13, 12 set, bit 10 as in RULE16, others clear; restart bit self-clears.
// [RULE19] Access uses clause 22 frames with strapped address and register zero.
`timescale 1ns/1ps
`default_nettype none

module pbc_control #(
    parameter int LMX_WIDTH = 3,
    parameter int PRE_BITS  = pbc_pkg::PRE_BITS_DEF
) (
    input  wire logic                 sys_clk,
    input  wire logic                 rstn,
    input  wire logic                 mdc,
    input  wire logic                 mdio_in,
    output logic                      mdio_out,
    output logic                      mdio_oe,
    input  wire logic [4:0]           phy_addr_pin,
    input  wire logic                 strap_mode_pin,
    input  wire logic                 speed_select_pin,
    input  wire logic                 autoneg_select_pin,
    input  wire logic                 duplex_select_pin,
    input  wire logic                 an_result_100,
    input  wire logic                 an_result_fd,
    input  wire logic                 link_speed_100,
    input  wire logic                 link_full_duplex,
    input  wire logic [LMX_WIDTH-1:0] sm_state,
    input  wire logic                 mii_tx_en,
    input  wire logic [3:0]           mii_txd,
    input  wire logic                 line_rx_dv,
    input  wire logic [3:0]           line_rxd,
    output logic                      mii_rx_dv,
    output logic [3:0]                mii_rxd,
    output logic                      tp_tx_en,
    output logic                      tp_rx_en,
    output logic                      col_detect_en,
    output logic                      speed_100,
    output logic                      full_duplex,
    output logic                      autoneg_en,
    output logic                      an_restart,
    output logic                      low_power,
    output logic                      isolate,
    output logic                      sw_reset_active
);

    if (LMX_WIDTH < 1 || LMX_WIDTH > pbc_pkg::LMX_MAX_W) begin : g_chk_lmx
        $error("LMX_WIDTH out of range");
    end
    if (PRE_BITS < 1 || PRE_BITS > 63) begin : g_chk_pre
        $error("PRE_BITS out of range");
    end

    localparam logic [5:0] PRE_CNT   = 6'(PRE_BITS);
    localparam logic [7:0] SWR_LOAD  = 8'(pbc_pkg::SW_RESET_CYCLES);
    localparam int         A_SWR     = pbc_pkg::SW_RESET_CYCLES;
    localparam int         A_SWR_M1  = pbc_pkg::SW_RESET_CYCLES - 1;

    // ****************************************
    // State
    // ****************************************
    pbc_pkg::pbc_mdio_e       md_state_reg;
    logic                     mdc_d_reg;
    logic [5:0]               cnt_reg;
    logic [15:0]              shift_reg;
    logic                     op_rd_reg;
    logic [4:0]               addr_reg;
    logic [4:0]               phy_addr_reg;
    logic                     wr_pulse_reg;
    logic                     lmx_rd_pulse_reg;
    logic [7:0]               swr_cnt_reg;
    logic [LMX_WIDTH-1:0]     max_trk_reg;
    logic loop_reg, rate_reg, anen_reg, lpwr_reg, iso_reg, anrst_reg, dup_reg, ctest_reg;

    logic        mdc_rise;
    logic [13:0] hdr;
    logic        sw_busy;
    logic        sw_done;
    logic        hdr_ok;
    logic [15:0] ctrl_rd;
    logic [15:0] dstat_rd;
    logic [15:0] rd_val;
    logic [15:0] lmx_field;

    assign mdc_rise = mdc & ~mdc_d_reg;
    assign hdr      = {shift_reg[12:0], mdio_in};
    assign sw_busy  = swr_cnt_reg != 8'h00;
    assign sw_done  = swr_cnt_reg == 8'h01;
    assign hdr_ok   = hdr[13:12] == pbc_pkg::FR_START && hdr[9:5] == phy_addr_reg;

    always_comb
    begin
        lmx_field = 16'h0000;
        lmx_field[pbc_pkg::DB_LMX_LO +: LMX_WIDTH] = max_trk_reg;
        ctrl_rd = 16'h0000;                          // Reserved low bits read zero [RULE17]
        ctrl_rd[pbc_pkg::CB_RESET]  = sw_busy;       // [RULE6]
        ctrl_rd[pbc_pkg::CB_LOOP]   = loop_reg;
        ctrl_rd[pbc_pkg::CB_RATE]   = rate_reg;
        ctrl_rd[pbc_pkg::CB_ANEN]   = anen_reg;
        ctrl_rd[pbc_pkg::CB_LPWR]   = lpwr_reg;
        ctrl_rd[pbc_pkg::CB_ISO]    = iso_reg;
        ctrl_rd[pbc_pkg::CB_ANRST]  = anrst_reg;
        ctrl_rd[pbc_pkg::CB_DUPLEX] = dup_reg;
        ctrl_rd[pbc_pkg::CB_CTEST]  = ctest_reg;
        dstat_rd = lmx_field;
        dstat_rd[pbc_pkg::DB_RATE]   = link_speed_100;    // [RULE11]
        dstat_rd[pbc_pkg::DB_DUPLEX] = link_full_duplex;
        if (addr_reg == pbc_pkg::CTRL_ADDR)
            rd_val = ctrl_rd;                        // [RULE4]
        else if (addr_reg == pbc_pkg::DSTAT_ADDR)
            rd_val = dstat_rd;
        else
            rd_val = 16'h0000;
    end

    // ****************************************
    // Strapped address capture
    // ****************************************
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
            phy_addr_reg <= phy_addr_pin;
    end

    // ****************************************
    // Management frame engine
    // ****************************************
    // Soft reset drops any frame in flight so nothing lands half-written
    always_ff @(posedge sys_clk)
    begin
        mdc_d_reg        <= mdc;
        wr_pulse_reg     <= 1'b0;
        lmx_rd_pulse_reg <= 1'b0;
        if (!rstn || sw_busy)                        // [RULE5] [RULE6]
        begin
            md_state_reg <= pbc_pkg::MD_PRE;
            cnt_reg      <= 6'h00;
            shift_reg    <= 16'h0000;
            op_rd_reg    <= 1'b0;
            addr_reg     <= 5'h00;
            mdio_out     <= 1'b0;
            mdio_oe      <= 1'b0;
            if (!rstn)
                mdc_d_reg <= 1'b0;
        end
        else if (mdc_rise)
        begin
            unique case (md_state_reg)
                pbc_pkg::MD_PRE:
                begin
                    shift_reg <= {shift_reg[14:0], mdio_in};
                    if (mdio_in)
                        cnt_reg <= (cnt_reg < PRE_CNT) ? cnt_reg + 6'h01 : cnt_reg;
                    else if (cnt_reg == PRE_CNT)
                    begin
                        md_state_reg <= pbc_pkg::MD_HDR;
                        cnt_reg      <= 6'h01;
                    end
                    else
                        cnt_reg <= 6'h00;
                end
                pbc_pkg::MD_HDR:
                begin
                    shift_reg <= {shift_reg[14:0], mdio_in};
                    cnt_reg   <= cnt_reg + 6'h01;
                    if (cnt_reg == pbc_pkg::HDR_LAST)
                    begin
                        cnt_reg   <= 6'h00;
                        op_rd_reg <= hdr[11:10] == pbc_pkg::OP_READ;
                        addr_reg  <= hdr[4:0];
                        if (hdr_ok && (hdr[11:10] == pbc_pkg::OP_READ ||
                                       hdr[11:10] == pbc_pkg::OP_WRITE))   // [RULE19]
                            md_state_reg <= pbc_pkg::MD_TA;
                        else
                            md_state_reg <= pbc_pkg::MD_PRE;
                    end
                end
                pbc_pkg::MD_TA:
                begin
                    cnt_reg <= cnt_reg + 6'h01;
                    if (op_rd_reg)
                    begin
                        mdio_oe  <= 1'b1;
                        mdio_out <= 1'b0;
                    end
                    if (cnt_reg == pbc_pkg::TA_LAST)
                    begin
                        cnt_reg <= 6'h00;
                        if (op_rd_reg)
                        begin
                            shift_reg        <= rd_val;
                            mdio_out         <= rd_val[15];
                            lmx_rd_pulse_reg <= addr_reg == pbc_pkg::DSTAT_ADDR;
                            md_state_reg     <= pbc_pkg::MD_RDAT;
                        end
                        else
                            md_state_reg <= pbc_pkg::MD_WDAT;
                    end
                end
                pbc_pkg::MD_RDAT:
                begin
                    cnt_reg   <= cnt_reg + 6'h01;
                    shift_reg <= {shift_reg[14:0], 1'b0};
                    mdio_out  <= shift_reg[14];
                    if (cnt_reg == pbc_pkg::DATA_LAST)
                    begin
                        mdio_oe      <= 1'b0;
                        mdio_out     <= 1'b0;
                        cnt_reg      <= 6'h00;
                        md_state_reg <= pbc_pkg::MD_PRE;
                    end
                end
                pbc_pkg::MD_WDAT:
                begin
                    cnt_reg   <= cnt_reg + 6'h01;
                    shift_reg <= {shift_reg[14:0], mdio_in};
                    if (cnt_reg == pbc_pkg::DATA_LAST)
                    begin
                        wr_pulse_reg <= 1'b1;
                        cnt_reg      <= 6'h00;
                        md_state_reg <= pbc_pkg::MD_PRE;
                    end
                end
            endcase
        end
    end

    // ****************************************
    // Soft reset timer
    // ****************************************
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
            swr_cnt_reg <= 8'h00;
        else if (sw_busy)
            swr_cnt_reg <= swr_cnt_reg - 8'h01;      // Clears itself when done [RULE3] [RULE6]
        else if (wr_pulse_reg && addr_reg == pbc_pkg::CTRL_ADDR && shift_reg[pbc_pkg::CB_RESET])
            swr_cnt_reg <= SWR_LOAD;                 // [RULE5]
    end

    // ****************************************
    // Control register
    // ****************************************
    always_ff @(posedge sys_clk)
    begin
        if (!rstn || sw_done)                        // [RULE5] [RULE18]
        begin
            loop_reg  <= 1'b0;
            rate_reg  <= pbc_pkg::RATE_RST;
            anen_reg  <= pbc_pkg::ANEN_RST;
            lpwr_reg  <= 1'b0;
            iso_reg   <= (rstn ? phy_addr_reg : phy_addr_pin) == pbc_pkg::ISO_ADDR;  // [RULE16]
            anrst_reg <= 1'b0;
            dup_reg   <= 1'b0;
            ctest_reg <= 1'b0;
        end
        else if (wr_pulse_reg && addr_reg == pbc_pkg::CTRL_ADDR && !shift_reg[pbc_pkg::CB_RESET])
        begin
            loop_reg  <= shift_reg[pbc_pkg::CB_LOOP];
            rate_reg  <= shift_reg[pbc_pkg::CB_RATE];
            anen_reg  <= shift_reg[pbc_pkg::CB_ANEN];
            lpwr_reg  <= shift_reg[pbc_pkg::CB_LPWR];
            iso_reg   <= shift_reg[pbc_pkg::CB_ISO];
            // Restart only takes while autoneg is on in software mode
            anrst_reg <= shift_reg[pbc_pkg::CB_ANRST] && strap_mode_pin && anen_reg;
            dup_reg   <= shift_reg[pbc_pkg::CB_DUPLEX];
            ctest_reg <= shift_reg[pbc_pkg::CB_CTEST];
        end
        else if (anrst_reg)
            anrst_reg <= 1'b0;                       // Self-clears once restart is issued [RULE3] [RULE18]
    end

    // ****************************************
    // Maximum-tracking group
    // ****************************************
    always_ff @(posedge sys_clk)
    begin
        if (!rstn || sw_done)
            max_trk_reg <= '0;
        else if (lmx_rd_pulse_reg)
            max_trk_reg <= sm_state;                 // [RULE2]
        else if (sm_state > max_trk_reg)
            max_trk_reg <= sm_state;                 // [RULE1]
    end

    // ****************************************
    // Operating outputs
    // ****************************************
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            tp_tx_en        <= 1'b0;
            tp_rx_en        <= 1'b0;
            col_detect_en   <= 1'b0;
            speed_100       <= 1'b0;
            full_duplex     <= 1'b0;
            autoneg_en      <= 1'b0;
            an_restart      <= 1'b0;
            low_power       <= 1'b0;
            isolate         <= 1'b0;
            sw_reset_active <= 1'b0;
            mii_rx_dv       <= 1'b0;
            mii_rxd         <= 4'h0;
        end
        else
        begin
            tp_tx_en        <= !loop_reg;                // [RULE7]
            tp_rx_en        <= !loop_reg;                // [RULE7]
            col_detect_en   <= !loop_reg || ctest_reg;   // [RULE8]
            if (!strap_mode_pin)
            begin
                speed_100   <= speed_select_pin;         // [RULE10]
                full_duplex <= duplex_select_pin;
                autoneg_en  <= autoneg_select_pin;       // [RULE14]
            end
            else
            begin
                speed_100   <= anen_reg ? an_result_100 : rate_reg;  // [RULE12] [RULE13] [RULE15]
                full_duplex <= anen_reg ? an_result_fd : dup_reg;    // [RULE15]
                autoneg_en  <= anen_reg;                             // [RULE15]
            end
            an_restart      <= anrst_reg;
            low_power       <= lpwr_reg;
            isolate         <= iso_reg;
            sw_reset_active <= sw_busy;
            // One register of delay keeps loopback far below 512 bit times
            mii_rx_dv <= !iso_reg && (loop_reg ? mii_tx_en : line_rx_dv);   // [RULE9]
            mii_rxd   <= iso_reg ? 4'h0 : (loop_reg ? mii_txd : line_rxd);  // [RULE7]
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    sequence s_swr_start;
        $rose(sw_busy);
    endsequence
    sequence s_swr_hold;
        ##A_SWR_M1 sw_busy ##1 !sw_busy;
    endsequence

    property p_max_keep;
        // Soft reset end clears the group on purpose, so it is left out here
        !lmx_rd_pulse_reg && !sw_done && sm_state <= max_trk_reg
            |=> max_trk_reg == $past(max_trk_reg);
    endproperty
    a_max_keep: assert property (p_max_keep) else $error("max group lost value"); // [RULE1]

    property p_max_grow;
        !lmx_rd_pulse_reg && !sw_done && sm_state > max_trk_reg
            |=> max_trk_reg == $past(sm_state);
    endproperty
    a_max_grow: assert property (p_max_grow) else $error("max group missed a rise"); // [RULE1]

    property p_max_read;
        lmx_rd_pulse_reg |=> max_trk_reg == $past(sm_state);
    endproperty
    a_max_read: assert property (p_max_read) else $error("max group not reloaded"); // [RULE2]

    property p_swr_len;
        s_swr_start |-> s_swr_hold;
    endproperty
    a_swr_len: assert property (p_swr_len) else $error("soft reset length wrong"); // [RULE6]

    property p_swr_defaults;
        s_swr_start ##A_SWR 1'b1 |-> !loop_reg && rate_reg && anen_reg && !ctest_reg;
    endproperty
    a_swr_defaults: assert property (p_swr_defaults) else $error("defaults not restored"); // [RULE5]

    property p_swr_quiet;
        sw_busy |-> ctrl_rd[pbc_pkg::CB_RESET] && !mdio_oe && !wr_pulse_reg;
    endproperty
    a_swr_quiet: assert property (p_swr_quiet) else $error("access during soft reset"); // [RULE6]

    property p_restart_sc;
        anrst_reg && !wr_pulse_reg |=> !anrst_reg && an_restart;
    endproperty
    a_restart_sc: assert property (p_restart_sc) else $error("restart not self-cleared"); // [RULE3]

    property p_loop_line;
        loop_reg |=> !tp_tx_en && !tp_rx_en && (col_detect_en == $past(ctest_reg));
    endproperty
    a_loop_line: assert property (p_loop_line) else $error("loopback line control wrong"); // [RULE8]

    property p_loop_dv;
        loop_reg && !iso_reg && mii_tx_en ##1 loop_reg && !iso_reg |-> mii_rx_dv;
    endproperty
    a_loop_dv: assert property (p_loop_dv) else $error("loopback valid late"); // [RULE9]

    property p_hw_strap;
        !strap_mode_pin |=> speed_100 == $past(speed_select_pin)
                            && autoneg_en == $past(autoneg_select_pin);
    endproperty
    a_hw_strap: assert property (p_hw_strap) else $error("strap pins not followed"); // [RULE10]

    property p_sw_speed;
        strap_mode_pin |=> speed_100 == ($past(anen_reg) ? $past(an_result_100) : $past(rate_reg));
    endproperty
    a_sw_speed: assert property (p_sw_speed) else $error("software speed wrong"); // [RULE13]

    property p_reserved;
        // Also watch the serial read-out of the low bits, not only the mux
        ctrl_rd[6:0] == 7'h00 &&
        (md_state_reg != pbc_pkg::MD_RDAT || addr_reg != pbc_pkg::CTRL_ADDR ||
         cnt_reg < 6'h09 || !mdio_out);
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits not zero"); // [RULE17]

endmodule // pbc_control

`default_nettype wire

// [pbc_sta.sv]
/*
 * Station manager model: sends clause 22 frames on mdc and mdio.
 * Assumes a pull-up on mdio and a device that turns the bus round.
 */
`timescale 1ns/1ps
`default_nettype none

module pbc_sta (
    input  wire logic        sys_clk,
    input  wire logic        mdio_out,
    input  wire logic        mdio_oe,
    output logic             mdc,
    output logic             mdio_in,
    output logic             rd_done,
    output logic [15:0]      rd_data
);
    logic drv;

    // Wire level; our released level is the pull-up
    assign mdio_in = mdio_oe ? mdio_out : drv;

    initial
    begin
        mdc = 1'b0;
        drv = 1'b1;
        rd_done = 1'b0;
        rd_data = 16'h0000;
    end

    // Clock stands low between frames; the model changes its own drive only while mdc is low
    task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                         input logic [15:0] wd);
        logic [63:0] f;
        f = {32'hFFFF_FFFF, pbc_pkg::FR_START, op, pa, ra,
             (op == pbc_pkg::OP_WRITE) ? {2'b10, wd} : 18'h3_FFFF};
        for (int i = 63; i >= 0; i--)
        begin
            @(negedge sys_clk);
            mdc = 1'b0;
            drv = f[i];
            repeat (2) @(negedge sys_clk);
            if (i < 16)
                rd_data = {rd_data[14:0], mdio_in};
            mdc = 1'b1;
            repeat (2) @(negedge sys_clk);
        end
        mdc = 1'b0;
        drv = 1'b1;
        rd_done = (op == pbc_pkg::OP_READ);
        @(negedge sys_clk);
        rd_done = 1'b0;
    endtask
endmodule // pbc_sta

`default_nettype wire

// [phy_basic_control_register_tb.sv]
/*
 * Self-checking bench for the basic control register block.
 * Assumes the station manager model drives the management port.
 */
`timescale 1ns/1ps
`default_nettype none

module phy_basic_control_register_tb;
    logic        sys_clk, rstn, mdc, mdio_in, mdio_out, mdio_oe, rd_done;
    logic        strap_mode_pin, speed_select_pin, autoneg_select_pin, duplex_select_pin;
    logic        an_result_100, an_result_fd, link_speed_100, link_full_duplex;
    logic        mii_tx_en, line_rx_dv, mii_rx_dv, tp_tx_en, tp_rx_en, col_detect_en;
    logic        speed_100, full_duplex, autoneg_en, an_restart, low_power, isolate;
    logic        sw_reset_active;
    logic [4:0]  phy_addr_pin;
    logic [2:0]  sm_state;
    logic [3:0]  mii_txd, line_rxd, mii_rxd;
    logic [15:0] rd_data;
    logic [15:0] exp_q[$];
    int          err_total, n_compared, n_rst;

    pbc_control uut (.sys_clk, .rstn, .mdc, .mdio_in, .mdio_out, .mdio_oe, .phy_addr_pin,
        .strap_mode_pin, .speed_select_pin, .autoneg_select_pin, .duplex_select_pin,
        .an_result_100, .an_result_fd, .link_speed_100, .link_full_duplex, .sm_state,
        .mii_tx_en, .mii_txd, .line_rx_dv, .line_rxd, .mii_rx_dv, .mii_rxd, .tp_tx_en,
        .tp_rx_en, .col_detect_en, .speed_100, .full_duplex, .autoneg_en, .an_restart,
        .low_power, .isolate, .sw_reset_active);
    pbc_sta sta (.sys_clk, .mdio_out, .mdio_oe, .mdc, .mdio_in, .rd_done, .rd_data);

    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    task automatic summarize();
        if (err_total == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e)
        begin
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
            err_total++;
        end
    endtask

    task automatic chk1(input string nm, input logic e, input logic g);
        chk16(nm, {15'h0000, e}, {15'h0000, g});
    endtask

    task automatic rd(input logic [4:0] ra, input logic [15:0] e);
        exp_q.push_back(e);
        sta.frame(pbc_pkg::OP_READ, phy_addr_pin, ra, 16'hFFFF);
    endtask

    // Writes land a few cycles after the last data rise
    task automatic wr(input logic [15:0] d);
        sta.frame(pbc_pkg::OP_WRITE, phy_addr_pin, pbc_pkg::CTRL_ADDR, d);
        repeat (3) @(negedge sys_clk);
    endtask

    task automatic do_reset();
        rstn = 1'b0;
        repeat (5) @(negedge sys_clk);
        rstn = 1'b1;
        repeat (2) @(negedge sys_clk);
    endtask

    // Read results are matched against the oldest expectation
    always @(posedge sys_clk)
        if (rd_done === 1'b1)
            chk16("read", exp_q.pop_front(), rd_data);

    always @(posedge sys_clk)
        if (an_restart === 1'b1)
            n_rst++;

    initial
    begin
        repeat (20000) @(posedge sys_clk);
        err_total++;
        summarize();
    end

    initial
    begin
        n_rst = $urandom(99);
        {err_total, n_compared, n_rst} = '0;
        {rstn, mii_tx_en, sm_state, mii_txd} = '0;
        {speed_select_pin, autoneg_select_pin, duplex_select_pin, an_result_100} = 4'($urandom());
        {an_result_fd, link_speed_100, link_full_duplex, line_rx_dv} = 4'($urandom());
        line_rxd = 4'($urandom());
        strap_mode_pin = 1'b1;
        phy_addr_pin = 5'h03;
        do_reset();
        rd(pbc_pkg::CTRL_ADDR, 16'h3000);
        rd(5'h02, 16'h0000);
        exp_q.push_back(16'hFFFF);
        sta.frame(pbc_pkg::OP_READ, ~phy_addr_pin, 5'h00, 16'hFFFF);
        wr(16'h4100);
        rd(pbc_pkg::CTRL_ADDR, 16'h4100);
        chk1("tp_tx_en", 1'b0, tp_tx_en);
        chk1("tp_rx_en", 1'b0, tp_rx_en);
        chk1("col_detect_en", 1'b0, col_detect_en);
        chk1("speed_100", 1'b0, speed_100);
        chk1("full_duplex", 1'b1, full_duplex);
        chk1("autoneg_en", 1'b0, autoneg_en);
        wr(16'h6980);
        chk1("low_power", 1'b1, low_power);
        chk1("col_detect_en", 1'b1, col_detect_en);
        chk1("speed_100", 1'b1, speed_100);
        mii_txd = 4'($urandom());
        mii_tx_en = 1'b1;
        // 512 bit times at 100 Mbps is about 102 cycles
        for (int k = 0; k < 102 && mii_rx_dv !== 1'b1; k++)
            @(negedge sys_clk);
        chk1("mii_rx_dv", 1'b1, mii_rx_dv);
        chk16("mii_rxd", {12'h000, mii_txd}, {12'h000, mii_rxd});
        mii_tx_en = 1'b0;
        wr(16'h1000);
        chk1("speed_100", an_result_100, speed_100);
        chk1("autoneg_en", 1'b1, autoneg_en);
        chk1("full_duplex", an_result_fd, full_duplex);
        chk1("mii_rx_dv", line_rx_dv, mii_rx_dv);
        chk16("mii_rxd", {12'h000, line_rxd}, {12'h000, mii_rxd});
        wr(16'h1200);
        chk1("an_restart", 1'b1, n_rst == 1);
        rd(pbc_pkg::CTRL_ADDR, 16'h1000);
        sm_state = 3'h3;
        repeat (4) @(negedge sys_clk);
        sm_state = 3'h2;
        rd(pbc_pkg::DSTAT_ADDR, {link_speed_100, link_full_duplex, 3'h3, 11'h000});
        rd(pbc_pkg::DSTAT_ADDR, {link_speed_100, link_full_duplex, 3'h2, 11'h000});
        strap_mode_pin = 1'b0;
        {speed_select_pin, autoneg_select_pin} = 2'($urandom());
        repeat (3) @(negedge sys_clk);
        chk1("speed_100", speed_select_pin, speed_100);
        chk1("autoneg_en", autoneg_select_pin, autoneg_en);
        rd(pbc_pkg::DSTAT_ADDR, {link_speed_100, link_full_duplex, 3'h2, 11'h000});
        strap_mode_pin = 1'b1;
        wr(16'h4100);
        wr(16'h8000);
        chk1("sw_reset_active", 1'b1, sw_reset_active);
        repeat (pbc_pkg::SW_RESET_CYCLES + 4) @(negedge sys_clk);
        chk1("sw_reset_active", 1'b0, sw_reset_active);
        chk1("tp_tx_en", 1'b1, tp_tx_en);
        rd(pbc_pkg::CTRL_ADDR, 16'h3000);
        phy_addr_pin = 5'h00;
        do_reset();
        chk1("isolate", 1'b1, isolate);
        rd(pbc_pkg::CTRL_ADDR, 16'h3400);
        repeat (2) @(negedge sys_clk);
        summarize();
    end
endmodule // phy_basic_control_register_tb

`default_nettype wire
